// ==== inc/cies_pkg.sv ====
/*
  Shared constants and types for the instruction execution subset block:
  operation selects, widths, reset values and cycle counts.
  Assumes the core decodes instruction words into one of these selects.
*/
`default_nettype none

package cies_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int PC_W = 13;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;

  // ----------------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
  localparam logic ZERO_FLAG_RESET = 1'b0;
  localparam logic EXPIRY_FLAG_N_RESET = 1'b1;
  localparam logic SLEEP_FLAG_N_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------------
  localparam int CALL_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;
  localparam int PLAIN_CYCLES = 1;

  // ----------------------------------------------------------------------
  // Operation selects and controller states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_WATCHDOG_CLEAR = 3'h0,
    OP_CALL = 3'h1,
    OP_REGISTER_INVERT = 3'h2,
    OP_REGISTER_ZEROING = 3'h3,
    OP_REGISTER_DECREMENT = 3'h4,
    OP_ACCUMULATOR_ZEROING = 3'h5,
    OP_DECREMENT_SKIP = 3'h6,
    OP_NO_OPERATION = 3'h7
  } cies_op_type;

  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_SECOND = 2'b10
  } cies_state_type;

endpackage

`default_nettype wire

// ==== rtl/cies_zero_det.sv ====
/*
  Zero detector of parameterised width.
  Assumes a purely combinational use inside the execution block.
*/
`default_nettype none

module cies_zero_det #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] value_i,
  output logic zero_o
);

  // ----------------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------------
  // High when every bit of the value is clear.
  assign zero_o = ~(|value_i);

endmodule

`default_nettype wire

// ==== rtl/cies_exec.sv ====
/*
  Execution unit for a subset of an 8-bit core's instructions: watchdog
  clear, subroutine call, register invert, register and accumulator
  zeroing, decrement and decrement-with-skip.
  Assumes the core presents a decoded operation with its operands, the
  addressed file register contents, the current program counter and the
  high latch, all synchronous to clk_i, and acts on the registered
  strobes that this unit drives back.
*/
`default_nettype none

// Behaviour
// (RULE1) Watchdog clear zeroes counter and prescaler.
// (RULE2) Watchdog clear sets both active-low flags.
// (RULE3) Call pushes program counter plus one.
// (RULE4) Call loads literal into counter bits 10:0.
// (RULE5) Counter bits 12:11 come from latch 4:3.
// (RULE6) Call takes two cycles, flags unchanged.
// (RULE7) Invert register, route by destination, zero updated.
// (RULE8) Register zeroing writes zero, sets zero flag.
// (RULE9) Accumulator zeroing loads zero, sets zero flag.
// (RULE10) Decrement register, route by destination, zero updated.
// (RULE11) Decrement-skip routes result, keeps all flags.
// (RULE12) Zero result discards next, two cycles.
// (RULE13) Zero flag follows eight-bit result being zero.
// (RULE14) Other operations finish in one cycle.
module cies_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire cies_pkg::cies_op_type op_i,
  input wire logic [cies_pkg::ADDR_W-1:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [cies_pkg::LIT_W-1:0] literal_i,
  input wire logic [cies_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic [cies_pkg::PC_W-1:0] program_counter_i,
  input wire logic [cies_pkg::DATA_W-1:0] program_counter_high_latch_i,
  input wire logic watchdog_expiry_event_i,
  input wire logic sleep_entry_event_i,
  output logic busy_o,
  output logic done_o,
  output logic [cies_pkg::DATA_W-1:0] accum_o,
  output logic zero_flag_o,
  output logic watchdog_expiry_flag_n_o,
  output logic sleep_entry_flag_n_o,
  output logic file_we_o,
  output logic [cies_pkg::ADDR_W-1:0] file_waddr_o,
  output logic [cies_pkg::DATA_W-1:0] file_wdata_o,
  output logic stack_push_o,
  output logic [cies_pkg::PC_W-1:0] stack_top_o,
  output logic pc_load_o,
  output logic [cies_pkg::PC_W-1:0] pc_load_value_o,
  output logic watchdog_clear_o,
  output logic prescaler_clear_o,
  output logic discard_next_o
);

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  cies_pkg::cies_state_type state_reg;
  cies_pkg::cies_state_type state_next;
  logic busy_reg;
  logic done_reg;
  logic [cies_pkg::DATA_W-1:0] accum_reg;
  logic [cies_pkg::DATA_W-1:0] accum_next;
  logic zero_flag_reg;
  logic zero_flag_next;
  logic expiry_n_reg;
  logic expiry_n_next;
  logic sleep_n_reg;
  logic sleep_n_next;
  logic file_we_reg;
  logic [cies_pkg::ADDR_W-1:0] file_waddr_reg;
  logic [cies_pkg::DATA_W-1:0] file_wdata_reg;
  logic stack_push_reg;
  logic [cies_pkg::PC_W-1:0] stack_top_reg;
  logic pc_load_reg;
  logic [cies_pkg::PC_W-1:0] pc_load_value_reg;
  logic watchdog_clear_reg;
  logic discard_reg;

  // ----------------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------------
  // An operation is taken only while no two-cycle operation is running.
  wire take = op_valid_i & (state_reg == cies_pkg::ST_READY);
  wire is_wdt = take & (op_i == cies_pkg::OP_WATCHDOG_CLEAR);
  wire is_call = take & (op_i == cies_pkg::OP_CALL);
  wire is_inv = take & (op_i == cies_pkg::OP_REGISTER_INVERT);
  wire is_rzero = take & (op_i == cies_pkg::OP_REGISTER_ZEROING);
  wire is_dec = take & (op_i == cies_pkg::OP_REGISTER_DECREMENT);
  wire is_azero = take & (op_i == cies_pkg::OP_ACCUMULATOR_ZEROING);
  wire is_dskip = take & (op_i == cies_pkg::OP_DECREMENT_SKIP);
  wire is_arith = is_inv | is_dec | is_dskip;

  // ----------------------------------------------------------------------
  // Result datapath
  // ----------------------------------------------------------------------
  // Invert or decrement the addressed register; the zeroing forms give zero.
  wire [cies_pkg::DATA_W-1:0] inv_res = ~file_rdata_i; // RULE7
  wire [cies_pkg::DATA_W-1:0] dec_res = file_rdata_i - cies_pkg::ONE_BYTE; // RULE10 RULE11
  wire [cies_pkg::DATA_W-1:0] arith_res = is_inv ? inv_res : dec_res;
  wire [cies_pkg::DATA_W-1:0] result = is_arith ? arith_res : cies_pkg::ZERO_BYTE; // RULE8 RULE9
  wire res_zero;

  cies_zero_det #(
    .WIDTH(cies_pkg::DATA_W)
  ) cies_zero_det_i (
    .value_i(result),
    .zero_o(res_zero)
  );

  // The destination bit steers arithmetic results; zeroing forms are fixed.
  wire to_file = (is_arith & dest_i) | is_rzero; // RULE7 RULE10 RULE11 RULE8
  wire to_acc = (is_arith & ~dest_i) | is_azero; // RULE9
  // Only invert and plain decrement follow the result; decrement-skip does not.
  wire zero_upd = is_inv | is_dec; // RULE13 RULE11
  wire zero_set = is_rzero | is_azero; // RULE8 RULE9
  wire skip_taken = is_dskip & res_zero; // RULE12
  wire two_cycle = is_call | skip_taken; // RULE6 RULE12

  // Return address and paged target for a subroutine call.
  wire [cies_pkg::PC_W-1:0] return_addr = program_counter_i + cies_pkg::PC_STEP; // RULE3
  wire [1:0] page_bits = program_counter_high_latch_i[cies_pkg::LATCH_PAGE_HI:cies_pkg::LATCH_PAGE_LO];
  wire [cies_pkg::PC_W-1:0] call_target = {page_bits, literal_i}; // RULE4 RULE5

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Two-cycle forms spend one extra cycle, the discarded or flushed slot.
  assign state_next = two_cycle ? cies_pkg::ST_SECOND : cies_pkg::ST_READY; // RULE6 RULE12 RULE14
  assign accum_next = to_acc ? result : accum_reg;
  assign zero_flag_next = zero_set ? 1'b1 : (zero_upd ? res_zero : zero_flag_reg); // RULE13 RULE6
  // A watchdog expiry or sleep entry in the same cycle wins over the set.
  assign expiry_n_next = watchdog_expiry_event_i ? 1'b0 : (is_wdt ? 1'b1 : expiry_n_reg); // RULE2
  assign sleep_n_next = sleep_entry_event_i ? 1'b0 : (is_wdt ? 1'b1 : sleep_n_reg); // RULE2

  // ----------------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------------
  // The state register tracks the second cycle of two-cycle forms.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= cies_pkg::ST_READY;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      case (state_reg)
        cies_pkg::ST_READY: begin
          state_reg <= state_next;
          busy_reg <= two_cycle;
          done_reg <= take & ~two_cycle; // RULE14
        end
        cies_pkg::ST_SECOND: begin
          state_reg <= cies_pkg::ST_READY;
          busy_reg <= 1'b0;
          done_reg <= 1'b1; // RULE6 RULE12
        end
        default: begin
          state_reg <= cies_pkg::ST_READY;
          busy_reg <= 1'b0;
          done_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------------
  // Accumulator and status flags owned by this unit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_reg <= cies_pkg::ACCUM_RESET;
      zero_flag_reg <= cies_pkg::ZERO_FLAG_RESET;
      expiry_n_reg <= cies_pkg::EXPIRY_FLAG_N_RESET;
      sleep_n_reg <= cies_pkg::SLEEP_FLAG_N_RESET;
    end else begin
      accum_reg <= accum_next;
      zero_flag_reg <= zero_flag_next;
      expiry_n_reg <= expiry_n_next;
      sleep_n_reg <= sleep_n_next;
    end
  end

  // ----------------------------------------------------------------------
  // Strobes to the core
  // ----------------------------------------------------------------------
  // One-cycle strobes; their data hold until the next operation that raises the same strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_we_reg <= 1'b0;
      file_waddr_reg <= '0;
      file_wdata_reg <= cies_pkg::ZERO_BYTE;
      stack_push_reg <= 1'b0;
      stack_top_reg <= cies_pkg::PC_RESET;
      pc_load_reg <= 1'b0;
      pc_load_value_reg <= cies_pkg::PC_RESET;
      watchdog_clear_reg <= 1'b0;
      discard_reg <= 1'b0;
    end else begin
      file_we_reg <= to_file;
      stack_push_reg <= is_call; // RULE3
      pc_load_reg <= is_call; // RULE4
      watchdog_clear_reg <= is_wdt; // RULE1
      discard_reg <= skip_taken; // RULE12
      if (to_file) begin
        file_waddr_reg <= file_addr_i;
        file_wdata_reg <= result;
      end
      if (is_call) begin
        stack_top_reg <= return_addr; // RULE3
        pc_load_value_reg <= call_target; // RULE4 RULE5
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a flip-flop.
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign accum_o = accum_reg;
  assign zero_flag_o = zero_flag_reg;
  assign watchdog_expiry_flag_n_o = expiry_n_reg;
  assign sleep_entry_flag_n_o = sleep_n_reg;
  assign file_we_o = file_we_reg;
  assign file_waddr_o = file_waddr_reg;
  assign file_wdata_o = file_wdata_reg;
  assign stack_push_o = stack_push_reg;
  assign stack_top_o = stack_top_reg;
  assign pc_load_o = pc_load_reg;
  assign pc_load_value_o = pc_load_value_reg;
  // Counter and prescaler are cleared by the same strobe.
  assign watchdog_clear_o = watchdog_clear_reg; // RULE1
  assign prescaler_clear_o = watchdog_clear_reg; // RULE1
  assign discard_next_o = discard_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_wdt_clear_strobes: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    is_wdt |=> watchdog_clear_o && prescaler_clear_o ##1 watchdog_clear_o == $past(is_wdt))
    else $error("watchdog clear strobes wrong");

  a_wdt_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    is_wdt && !watchdog_expiry_event_i && !sleep_entry_event_i
    |=> watchdog_expiry_flag_n_o && sleep_entry_flag_n_o && $stable(zero_flag_o))
    else $error("watchdog clear flags wrong");

  a_call_push_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    is_call |=> stack_push_o && stack_top_o == $past(program_counter_i) + 13'h0001)
    else $error("call return address wrong");

  a_call_target: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    is_call |=> pc_load_o && pc_load_value_o[10:0] == $past(literal_i))
    else $error("call low target wrong");

  a_call_page: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    is_call |=> pc_load_value_o[12:11] == $past(program_counter_high_latch_i[4:3]))
    else $error("call page bits wrong");

  a_call_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    is_call |=> busy_o && !done_o && $stable(zero_flag_o) ##1 done_o && !busy_o)
    else $error("call timing wrong");

  a_invert_file: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    is_inv && dest_i |=> file_we_o && file_wdata_o == ~$past(file_rdata_i)
      && file_waddr_o == $past(file_addr_i))
    else $error("invert to file wrong");

  a_reg_zeroing: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    is_rzero |=> file_we_o && file_wdata_o == 8'h00 && zero_flag_o)
    else $error("register zeroing wrong");

  a_acc_zeroing: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    is_azero |=> accum_o == 8'h00 && zero_flag_o && !file_we_o)
    else $error("accumulator zeroing wrong");

  a_decrement_acc: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    is_dec && !dest_i |=> accum_o == $past(file_rdata_i) - 8'h01 && !file_we_o)
    else $error("decrement to accumulator wrong");

  a_dskip_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    is_dskip |=> $stable(zero_flag_o) && file_we_o == $past(dest_i))
    else $error("decrement skip flags or routing wrong");

  a_dskip_taken: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    is_dskip && file_rdata_i == 8'h01 |=> discard_next_o && busy_o ##1 done_o && !discard_next_o)
    else $error("taken skip wrong");

  a_zero_follows: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    is_inv || is_dec |=> zero_flag_o == ($past(is_inv) ? $past(file_rdata_i) == 8'hFF
      : $past(file_rdata_i) == 8'h01))
    else $error("zero flag does not follow result");

  a_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    take && !is_call && !(is_dskip && file_rdata_i == 8'h01) |=> done_o && !busy_o)
    else $error("single cycle operation wrong");

endmodule

`default_nettype wire

// ==== sim/cies_exec_bench.sv ====
/*
  Self-checking bench for the instruction execution subset unit.
  Assumes the unit takes an operation on the edge where op_valid_i is high
  and busy_o is low, and shows its strobes just after that edge.
*/
`default_nettype none

module cies_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Step table type and stimulus signals
  // ----------------------------------------------------------------------
  typedef struct {
    cies_pkg::cies_op_type op;
    logic [6:0] addr;
    logic dest;
    logic [7:0] rdata;
    logic [10:0] lit;
    logic [12:0] pc;
    logic [7:0] lat;
    logic two;
    logic we;
    logic [7:0] wdata;
    logic [7:0] acc;
    logic z;
    logic push;
    logic disc;
    logic wdc;
  } cies_step_type;

  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic op_valid_i = 1'h0;
  cies_pkg::cies_op_type op_i = cies_pkg::OP_NO_OPERATION;
  logic [6:0] file_addr_i = 7'h00;
  logic dest_i = 1'h0;
  logic [10:0] literal_i = 11'h000;
  logic [7:0] file_rdata_i = 8'h00;
  logic [12:0] program_counter_i = 13'h0000;
  logic [7:0] program_counter_high_latch_i = 8'h00;
  logic watchdog_expiry_event_i = 1'h0;
  logic sleep_entry_event_i = 1'h0;
  logic busy_o, done_o, zero_flag_o, watchdog_expiry_flag_n_o, sleep_entry_flag_n_o;
  logic file_we_o, stack_push_o, pc_load_o, watchdog_clear_o, prescaler_clear_o, discard_next_o;
  logic [7:0] accum_o, file_wdata_o;
  logic [6:0] file_waddr_o;
  logic [12:0] stack_top_o, pc_load_value_o;
  logic exp_to = 1'h1;
  logic exp_pd = 1'h1;
  int failures = 0;
  int tests_run = 0;
  cies_step_type steps[16];

  cies_exec cies_exec_i (
    .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i), .file_addr_i(file_addr_i),
    .dest_i(dest_i), .literal_i(literal_i), .file_rdata_i(file_rdata_i), .program_counter_i(program_counter_i),
    .program_counter_high_latch_i(program_counter_high_latch_i),
    .watchdog_expiry_event_i(watchdog_expiry_event_i), .sleep_entry_event_i(sleep_entry_event_i),
    .busy_o(busy_o), .done_o(done_o), .accum_o(accum_o), .zero_flag_o(zero_flag_o),
    .watchdog_expiry_flag_n_o(watchdog_expiry_flag_n_o), .sleep_entry_flag_n_o(sleep_entry_flag_n_o),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .stack_push_o(stack_push_o), .stack_top_o(stack_top_o), .pc_load_o(pc_load_o),
    .pc_load_value_o(pc_load_value_o), .watchdog_clear_o(watchdog_clear_o),
    .prescaler_clear_o(prescaler_clear_o), .discard_next_o(discard_next_o)
  );

  // The clock toggles every half period of 2 ns.
  always #2 clk_i = ~clk_i;

  // ----------------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  // Checks the quiet state that reset leaves behind.
  task automatic reset_values();
    chk_bit(busy_o, 1'h0);
    chk_bit(done_o, 1'h0);
    chk_val(16'(accum_o), 16'h0000);
    chk_bit(zero_flag_o, 1'h0);
    chk_bit(watchdog_expiry_flag_n_o, 1'h1);
    chk_bit(sleep_entry_flag_n_o, 1'h1);
    chk_bit(file_we_o, 1'h0);
    chk_bit(stack_push_o, 1'h0);
  endtask

  // Pulses the core's flag events for one cycle and checks the flags a cycle later.
  task automatic raise_events(input logic [1:0] ev);
    @(posedge clk_i);
    watchdog_expiry_event_i <= ev[0];
    sleep_entry_event_i <= ev[1];
    @(posedge clk_i);
    watchdog_expiry_event_i <= 1'h0;
    sleep_entry_event_i <= 1'h0;
    #1;
    exp_to = exp_to & ~ev[0];
    exp_pd = exp_pd & ~ev[1];
    chk_bit(watchdog_expiry_flag_n_o, exp_to);
    chk_bit(sleep_entry_flag_n_o, exp_pd);
  endtask

  // Offers one operation, then checks its answer cycle and the cycle after it.
  task automatic step(input cies_step_type s);
    @(posedge clk_i);
    op_valid_i <= 1'h1;
    op_i <= s.op;
    file_addr_i <= s.addr;
    dest_i <= s.dest;
    file_rdata_i <= s.rdata;
    literal_i <= s.lit;
    program_counter_i <= s.pc;
    program_counter_high_latch_i <= s.lat;
    @(posedge clk_i);
    op_valid_i <= 1'h0;
    #1;
    if (s.op == cies_pkg::OP_WATCHDOG_CLEAR) begin
      exp_to = 1'h1;
      exp_pd = 1'h1;
    end
    chk_bit(done_o, ~s.two);
    chk_bit(busy_o, s.two);
    chk_bit(file_we_o, s.we);
    if (s.we) begin
      chk_val(16'(file_waddr_o), 16'(s.addr));
      chk_val(16'(file_wdata_o), 16'(s.wdata));
    end
    chk_val(16'(accum_o), 16'(s.acc));
    chk_bit(zero_flag_o, s.z);
    chk_bit(stack_push_o, s.push);
    chk_bit(pc_load_o, s.push);
    if (s.push) begin
      chk_val(16'(stack_top_o), 16'(s.pc + 13'h0001));
      chk_val(16'(pc_load_value_o), 16'({s.lat[4:3], s.lit}));
    end
    chk_bit(discard_next_o, s.disc);
    chk_bit(watchdog_clear_o, s.wdc);
    chk_bit(prescaler_clear_o, s.wdc);
    chk_bit(watchdog_expiry_flag_n_o, exp_to);
    chk_bit(sleep_entry_flag_n_o, exp_pd);
    @(posedge clk_i);
    #1;
    chk_bit(done_o, s.two);
    chk_bit(busy_o, 1'h0);
    chk_bit(stack_push_o, 1'h0);
    chk_bit(discard_next_o, 1'h0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Fields: op, addr, dest, rdata, lit, pc, latch, two, we, wdata, acc, zero, push, discard, wdclear.
  initial begin
    steps = '{
      '{cies_pkg::OP_REGISTER_DECREMENT, 7'h05, 1'h0, 8'h00, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'hFF, 1'h0, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_ACCUMULATOR_ZEROING, 7'h05, 1'h0, 8'h33, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_CALL, 7'h00, 1'h0, 8'h00, 11'h7FF, 13'h0FFF, 8'h08,
        1'h1, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0, 1'h0},
      '{cies_pkg::OP_CALL, 7'h00, 1'h0, 8'h00, 11'h000, 13'h1234, 8'hE7,
        1'h1, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0, 1'h0},
      '{cies_pkg::OP_CALL, 7'h00, 1'h0, 8'h00, 11'h2AA, 13'h1FFE, 8'h10,
        1'h1, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1, 1'h0, 1'h0},
      '{cies_pkg::OP_WATCHDOG_CLEAR, 7'h00, 1'h0, 8'h00, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 1'h1},
      '{cies_pkg::OP_REGISTER_INVERT, 7'h7F, 1'h1, 8'h5A, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h1, 8'hA5, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_REGISTER_INVERT, 7'h12, 1'h0, 8'hFF, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_REGISTER_DECREMENT, 7'h01, 1'h1, 8'h00, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h1, 8'hFF, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_REGISTER_ZEROING, 7'h7F, 1'h0, 8'h99, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h1, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_REGISTER_DECREMENT, 7'h02, 1'h0, 8'h02, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'h01, 1'h0, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_DECREMENT_SKIP, 7'h03, 1'h0, 8'h05, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'h04, 1'h0, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_DECREMENT_SKIP, 7'h40, 1'h1, 8'h01, 11'h000, 13'h0000, 8'h00,
        1'h1, 1'h1, 8'h00, 8'h04, 1'h0, 1'h0, 1'h1, 1'h0},
      '{cies_pkg::OP_REGISTER_DECREMENT, 7'h04, 1'h0, 8'h01, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_DECREMENT_SKIP, 7'h05, 1'h0, 8'h00, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'hFF, 1'h1, 1'h0, 1'h0, 1'h0},
      '{cies_pkg::OP_NO_OPERATION, 7'h06, 1'h1, 8'h77, 11'h000, 13'h0000, 8'h00,
        1'h0, 1'h0, 8'h00, 8'hFF, 1'h1, 1'h0, 1'h0, 1'h0}
    };
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    reset_values();
    raise_events(2'h1);
    raise_events(2'h2);
    foreach (steps[k]) begin
      step(steps[k]);
    end
    raise_events(2'h3);
    @(posedge clk_i);
    rst_i <= 1'h1;
    @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    reset_values();
    complete_run();
  end

  // Cuts a hung run short and reports it as a failure.
  initial begin
    #100000;
    failures++;
    complete_run();
  end

endmodule

`default_nettype wire
